// File: design/bay_state_ctrl.v
/*
  Single bay state controller: bay state machine, bay control and status
  registers on a plain register port, presence and button synchronisers,
  power, lock, LED and alert outputs.
  Assumes presence and button pins are asynchronous and active low, and that
  the register master keeps to one-cycle strobes.
  One instance serves one bay; a dual-bay controller uses two.
  No insertion time-out: an enabled insertion acts as soon as it is seen.
  Status flags clear by writing one; a hardware set in the same cycle wins.
  FLASH_HALF_CYCLES counts core clocks per half flash period and may be
  shortened for simulation.
*/
// What this block does
// - button with device present sets request status
// - enabled request outside Empty enters Removal Requested, flashes, alerts
// - software code 011 enters Removal Requested
// - Removal Requested entered only with device present
// - Removal Requested flashes amber at 1Hz
// - Removal Allowed reached only by software write
// - software code 100 enters Removal Allowed if present
// - power and lock stay operable in Removal Allowed
// - from Removal Allowed software reaches any state but Empty
// - Removal Allowed still raises removal request events
// - no removal event from Removal Allowed when wake bit clear
// - wake and change enable set give event, alert
// - removal from Removal Allowed always goes Empty
// - Removal Allowed turns both LEDs off
// - reset to Empty, change enable cleared
// - Enabled to Removal Requested on enabled press
// - presence loss moves Inserted/Requested to Empty
// - state field at bits 6:4, fixed encoding
// - removal from any state but Empty clears power enable and request field
`timescale 1ns/100ps
`include "bay_state_defs.vh"

module bay_state_ctrl
#(
   parameter [31:0] FLASH_HALF_CYCLES = `FLASH_HALF_CYCLES
)
(
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Register port
   input wire [1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [7:0] regRdData,
   // Bay pins
   input wire serialBusPresenceN,
   input wire usbSidePresenceN,
   input wire removalRequestButtonN,
   output wire bayPowerEnable,
   output wire solenoidLockControl,
   output reg greenLedDrive,
   output reg amberLedDrive,
   output wire alertOutN
);

   localparam [4:0] ST_EMPTY = 5'h01;
   localparam [4:0] ST_INSERTED = 5'h02;
   localparam [4:0] ST_ENABLED = 5'h04;
   localparam [4:0] ST_REM_REQ = 5'h08;
   localparam [4:0] ST_REM_ALLOWED = 5'h10;

   // One-hot state to its 3-bit code
   function [2:0] stateCode;
      input [4:0] st;
      begin
         case (st)
            ST_INSERTED: stateCode = `CODE_INSERTED;
            ST_ENABLED: stateCode = `CODE_ENABLED;
            ST_REM_REQ: stateCode = `CODE_REM_REQ;
            ST_REM_ALLOWED: stateCode = `CODE_REM_ALLOWED;
            default: stateCode = `CODE_EMPTY;
         endcase
      end
   endfunction

   reg [1:0] serialSync_r;
   reg [1:0] usbSync_r;
   reg [1:0] buttonSync_r;
   reg buttonPrev_r;
   reg occupiedPrev_r;
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [7:0] control_r;
   reg [7:0] control_nxt;
   reg remReqStatus_r;
   reg remReqStatus_nxt;
   reg stsChange_r;
   reg stsChange_nxt;
   reg [31:0] flashCnt_r;
   reg flashPhase_r;
   wire serialPresent;
   wire usbPresent;
   wire occupied;
   wire buttonPress;
   wire removal;
   wire insertion;
   wire ctlWrite;
   wire stsWrite;
   wire [2:0] reqCode;
   wire [7:0] statusValue;
   wire stateChange;
   wire pressAccepted;
   wire insertEvent;
   wire reqAlert;
   wire changeAlert;

   // Two-stage synchronisers for the pins
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Pins idle high: no false press or removal after reset
         serialSync_r <= 2'h3;
         usbSync_r <= 2'h3;
         buttonSync_r <= 2'h3;
         buttonPrev_r <= 1'b0;
         occupiedPrev_r <= 1'b0;
      end
      else
      begin
         serialSync_r <= {serialSync_r[0], serialBusPresenceN};
         usbSync_r <= {usbSync_r[0], usbSidePresenceN};
         buttonSync_r <= {buttonSync_r[0], removalRequestButtonN};
         buttonPrev_r <= ~buttonSync_r[1];
         occupiedPrev_r <= occupied;
      end
   end

   assign serialPresent = ~serialSync_r[1];
   assign usbPresent = ~usbSync_r[1];
   assign occupied = serialPresent | usbPresent;
   assign removal = occupiedPrev_r & ~occupied;
   assign insertion = ~occupiedPrev_r & occupied;
   assign buttonPress = ~buttonSync_r[1] & ~buttonPrev_r;
   // press counts only with a device present
   assign pressAccepted = buttonPress & occupied;
   // Hardware insertion only from Empty with change enable set
   assign insertEvent = insertion & (state_r == ST_EMPTY) & control_r[`CTL_STSCHG_EN];

   assign ctlWrite = regWrite & (regAddr == `ADDR_BAY_CONTROL);
   assign stsWrite = regWrite & (regAddr == `ADDR_BAY_STATUS);
   assign reqCode = regWrData[`CTL_STREQ_MSB:`CTL_STREQ_LSB];

   // Next state, control and sticky status
   always @*
   begin
      state_nxt = state_r;
      control_nxt = control_r;
      remReqStatus_nxt = remReqStatus_r;
      stsChange_nxt = stsChange_r;
      // Status flags are write-one-to-clear; hardware sets below win
      if (stsWrite)
      begin
         if (regWrData[`STS_REMOVAL_REQUEST_BUTTON_IN])
            remReqStatus_nxt = 1'b0;
         if (regWrData[`STS_STSCHG])
            stsChange_nxt = 1'b0;
      end
      if (ctlWrite)
      begin
         control_nxt[7:3] = regWrData[7:3];
         control_nxt[`CTL_STREQ_MSB:`CTL_STREQ_LSB] = reqCode;
         if (occupied)
         begin
            case (reqCode)
               `CODE_INSERTED: state_nxt = ST_INSERTED;
               `CODE_ENABLED: state_nxt = ST_ENABLED;
               `CODE_REM_REQ: state_nxt = ST_REM_REQ;
               `CODE_REM_ALLOWED: state_nxt = ST_REM_ALLOWED;
               default: state_nxt = state_nxt;
            endcase
         end
      end
      if (pressAccepted)
      begin
         remReqStatus_nxt = 1'b1;
         if (control_nxt[`CTL_REMOVAL_REQUEST_ENABLE] & (state_r != ST_EMPTY))
            state_nxt = ST_REM_REQ;
      end
      // Enabled insertion raises a change event
      if (insertEvent)
      begin
         state_nxt = ST_INSERTED;
         stsChange_nxt = 1'b1;
      end
      // Removal last: it beats a same-cycle request or press
      if (removal & (state_r != ST_EMPTY))
      begin
         if (state_r == ST_REM_ALLOWED)
         begin
            // wake and enable give an event
            if (control_r[`CTL_REMWAKE] & control_r[`CTL_STSCHG_EN])
               stsChange_nxt = 1'b1;
         end
         else if (control_r[`CTL_STSCHG_EN])
            stsChange_nxt = 1'b1;
         state_nxt = ST_EMPTY;
         control_nxt[`CTL_PWR_EN] = 1'b0;
         control_nxt[`CTL_STREQ_MSB:`CTL_STREQ_LSB] = `CODE_EMPTY;
      end
   end

   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_EMPTY;
         control_r <= `CTL_RESET;
         remReqStatus_r <= 1'b0;
         stsChange_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         control_r <= control_nxt;
         remReqStatus_r <= remReqStatus_nxt;
         stsChange_r <= stsChange_nxt;
      end
   end

   assign stateChange = (state_nxt != state_r);

   // 1 Hz flash phase, restarted on a state change so that a new
   // flashing state opens with a full lit half period
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flashCnt_r <= 32'h0000_0000;
         flashPhase_r <= 1'b0;
      end
      else if (stateChange)
      begin
         flashCnt_r <= 32'h0000_0000;
         flashPhase_r <= 1'b1;
      end
      else if (flashCnt_r >= FLASH_HALF_CYCLES - 32'h0000_0001)
      begin
         flashCnt_r <= 32'h0000_0000;
         flashPhase_r <= ~flashPhase_r;
      end
      else
         flashCnt_r <= flashCnt_r + 32'h0000_0001;
   end

   // LED drive per state
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         greenLedDrive <= 1'b0;
         amberLedDrive <= 1'b0;
      end
      else
      begin
         case (state_r)
            ST_INSERTED:
            begin
               greenLedDrive <= flashPhase_r;
               amberLedDrive <= 1'b0;
            end
            ST_ENABLED:
            begin
               greenLedDrive <= 1'b1;
               amberLedDrive <= 1'b0;
            end
            ST_REM_REQ:
            begin
               greenLedDrive <= 1'b0;
               amberLedDrive <= flashPhase_r;
            end
            ST_REM_ALLOWED:
            begin
               greenLedDrive <= 1'b0;
               amberLedDrive <= 1'b0;
            end
            // Empty: both LEDs off
            default:
            begin
               greenLedDrive <= 1'b0;
               amberLedDrive <= 1'b0;
            end
         endcase
      end
   end

   assign bayPowerEnable = control_r[`CTL_PWR_EN];
   assign solenoidLockControl = control_r[`CTL_LOCK];

   assign reqAlert = remReqStatus_r & control_r[`CTL_REMOVAL_REQUEST_ENABLE];
   assign changeAlert = stsChange_r & control_r[`CTL_STSCHG_EN];
   // A late enable still raises the alert for a pending flag
   assign alertOutN = ~(reqAlert | changeAlert);

   assign statusValue = {1'b0, stateCode(state_r), stsChange_r, remReqStatus_r,
                         usbPresent, serialPresent};

   // Read data in the cycle after the strobe only
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 8'h00;
      else if (regRead)
      begin
         case (regAddr)
            `ADDR_BAY_CONTROL: regRdData <= control_r;
            `ADDR_BAY_STATUS: regRdData <= statusValue;
            default: regRdData <= 8'h00;
         endcase
      end
      // Zero outside the answer cycle
      else
         regRdData <= 8'h00;
   end

endmodule

// File: design/bay_state_defs.vh
/*
  Constants for the bay state controller: register offsets, field positions,
  state request codes, reset values and LED flash timing.
  Assumes a byte-wide register port and a 250 MHz core clock.
*/
`ifndef BAY_STATE_DEFS_VH
`define BAY_STATE_DEFS_VH

// Register offsets
`define ADDR_BAY_CONTROL 2'h0
`define ADDR_BAY_STATUS 2'h1

// Bay control register fields
`define CTL_STREQ_LSB 0
`define CTL_STREQ_MSB 2
`define CTL_STSCHG_EN 3
`define CTL_REMOVAL_REQUEST_ENABLE 4
`define CTL_REMWAKE 5
`define CTL_PWR_EN 6
`define CTL_LOCK 7
`define CTL_RESET 8'h00

// Bay status register fields
`define STS_SERIAL_PRS 0
`define STS_USB_PRS 1
`define STS_REMOVAL_REQUEST_BUTTON_IN 2
`define STS_STSCHG 3
`define STS_STATE_LSB 4
`define STS_STATE_MSB 6

// Bay state codes (state field and state request field)
`define CODE_EMPTY 3'h0
`define CODE_INSERTED 3'h1
`define CODE_ENABLED 3'h2
`define CODE_REM_REQ 3'h3
`define CODE_REM_ALLOWED 3'h4

// LED flash timing: 1 Hz, half period on, half off
`define CLK_PERIOD_NS 4
`define FLASH_PERIOD_NS 1000000000
`define FLASH_HALF_CYCLES (`FLASH_PERIOD_NS / `CLK_PERIOD_NS / 2)

`endif

// File: verif/bay_state_ctrl_checker.sv
/*
  Port assertions for the bay state controller.
  Assumes a bind to bay_state_ctrl, one clock domain.
*/
`timescale 1ns/100ps
module bay_state_ctrl_checker
#(
   parameter [31:0] FLASH_HALF_CYCLES = 8
)
(
   // Watched ports
   input wire clock,
   input wire rst_n,
   input wire [1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regRdData,
   input wire serialBusPresenceN,
   input wire usbSidePresenceN,
   input wire removalRequestButtonN,
   input wire bayPowerEnable,
   input wire solenoidLockControl,
   input wire greenLedDrive,
   input wire amberLedDrive,
   input wire alertOutN
);
   wire gone = serialBusPresenceN && usbSidePresenceN;
   wire ctlWr = regWrite && regAddr == 2'h0;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_rdIdle;
      !regRead |=> regRdData == 8'h00;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   property p_unmapped;
      regRead && regAddr[1] |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctlOut;
      ctlWr |=> bayPowerEnable == $past(regWrData[6]) && solenoidLockControl == $past(regWrData[7]);
   endproperty
   a_ctlOut: assert property (p_ctlOut) else $error("power or lock not from write");
   property p_reset;
      $rose(rst_n) |-> alertOutN && !bayPowerEnable && !greenLedDrive && !amberLedDrive;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not at reset value");
   property p_allowLeds;
      ctlWr && regWrData[2:0] == 3'h4 && !gone |-> ##2 !greenLedDrive && !amberLedDrive;
   endproperty
   a_allowLeds: assert property (p_allowLeds) else $error("led on in allowed");
   property p_emptyPower;
      $rose(gone) ##1 (gone && !regWrite) [*4] |-> !bayPowerEnable;
   endproperty
   a_emptyPower: assert property (p_emptyPower) else $error("power on when empty");
   property p_emptyLeds;
      (gone && !regWrite) [*6] |-> !greenLedDrive && !amberLedDrive;
   endproperty
   a_emptyLeds: assert property (p_emptyLeds) else $error("led on when empty");
   property p_powerDrop;
      $fell(bayPowerEnable) && !$past(regWrite) |-> $past(gone, 3);
   endproperty
   a_powerDrop: assert property (p_powerDrop) else $error("power dropped while occupied");
   c_press: cover property (!removalRequestButtonN && !gone);
   c_alert: cover property ($fell(alertOutN));
   c_flash: cover property ($rose(amberLedDrive));
endmodule

bind bay_state_ctrl bay_state_ctrl_checker #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) stateChecker
(
   .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .serialBusPresenceN(serialBusPresenceN), .usbSidePresenceN(usbSidePresenceN),
   .removalRequestButtonN(removalRequestButtonN), .bayPowerEnable(bayPowerEnable),
   .solenoidLockControl(solenoidLockControl), .greenLedDrive(greenLedDrive),
   .amberLedDrive(amberLedDrive), .alertOutN(alertOutN)
);

// File: verif/bay_pins_model.sv
/*
  Far side of the bay: two presence contacts and the removal button.
  Assumes the pins idle high through pull-ups when released.
*/
`timescale 1ns/100ps
module bay_pins_model
(
   // Bench commands
   input wire insA,
   input wire insB,
   input wire press,
   // Pins toward the controller
   output wire sPN,
   output wire uPN,
   output wire btnN
);
   assign sPN = !insA;
   assign uPN = !insB;
   assign btnN = !press;
endmodule

// File: verif/device_bay_state_controller_tb.sv
/*
  Testbench for the bay state controller.
  Assumes the defs header is on the include path.
*/
`timescale 1ns/100ps
`include "bay_state_defs.vh"
module device_bay_state_controller_tb;
   logic clock, rst_n, regWrite, regRead, insA, insB, press, a;
   logic [1:0] regAddr;
   logic [7:0] regWrData, regRdData, rdv;
   wire sPN, uPN, btnN, pwr, lock, grn, amb, alertN;
   int numErrors, testsRun;
   bay_pins_model pins (.insA(insA), .insB(insB), .press(press), .sPN(sPN), .uPN(uPN),
      .btnN(btnN));
   bay_state_ctrl #(.FLASH_HALF_CYCLES(8)) dut (.clock(clock), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .serialBusPresenceN(sPN), .usbSidePresenceN(uPN),
      .removalRequestButtonN(btnN), .bayPowerEnable(pwr), .solenoidLockControl(lock),
      .greenLedDrive(grn), .amberLedDrive(amb), .alertOutN(alertN));
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      testsRun++;
      if (s !== e)
      begin
         numErrors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [1:0] ad);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge clock);
      regRead <= 1'b0;
      #1 rdv = regRdData;
   endtask
   task st(input logic [2:0] e);
      rd(2'h1);
      chk("state", {5'h0, rdv[6:4]}, {5'h0, e});
   endtask
   task pr;
      @(posedge clock);
      press <= 1'b1;
      repeat (6) @(posedge clock);
      press <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task place(input logic a0, input logic b0);
      @(posedge clock);
      insA <= a0;
      insB <= b0;
   endtask
   task s_reset;
      rd(2'h0);
      chk("control", rdv, `CTL_RESET);
      st(`CODE_EMPTY);
      rd(2'h2);
      chk("unmapped", rdv, 8'h00);
      wr(2'h1, 8'h0C);
   endtask
   task s_swRequest;
      wr(2'h0, 8'h03);
      st(`CODE_REM_REQ);
      a = amb;
      wt(8);
      chk("amber", {7'h0, amb}, {7'h0, ~a});
   endtask
   task s_allowed;
      wr(2'h0, 8'hC4);
      st(`CODE_REM_ALLOWED);
      wt(2);
      chk("leds", {6'h0, grn, amb}, 8'h00);
      chk("pwrlock", {6'h0, pwr, lock}, 8'h03);
   endtask
   task s_pressAllowed;
      wr(2'h0, 8'hD4);
      pr;
      rd(2'h1);
      chk("status", rdv & 8'h74, 8'h34);
      chk("alert", {7'h0, alertN}, 8'h00);
      wr(2'h1, 8'h04);
      wt(1);
      chk("alert", {7'h0, alertN}, 8'h01);
   endtask
   task s_leave;
      wr(2'h0, 8'hD4);
      st(`CODE_REM_ALLOWED);
      wr(2'h0, 8'hD0);
      st(`CODE_REM_ALLOWED);
      wr(2'h0, 8'hD2);
      st(`CODE_ENABLED);
      pr;
      st(`CODE_REM_REQ);
      wr(2'h1, 8'h04);
   endtask
   task s_removeQuiet;
      wr(2'h0, 8'h4C);
      st(`CODE_REM_ALLOWED);
      place(1'b0, 1'b0);
      wt(6);
      st(`CODE_EMPTY);
      chk("alert", {7'h0, alertN}, 8'h01);
      rd(2'h0);
      chk("control", rdv, 8'h08);
   endtask
   task s_removeWake;
      place(1'b0, 1'b1);
      wt(6);
      st(`CODE_INSERTED);
      wr(2'h1, 8'h08);
      wr(2'h0, 8'h2C);
      place(1'b0, 1'b0);
      wt(6);
      chk("alert", {7'h0, alertN}, 8'h00);
      st(`CODE_EMPTY);
      wr(2'h1, 8'h08);
   endtask
   task s_forced;
      wr(2'h0, 8'h00);
      place(1'b1, 1'b0);
      wt(6);
      st(`CODE_EMPTY);
      wr(2'h0, 8'h03);
      st(`CODE_REM_REQ);
      place(1'b0, 1'b0);
      wt(6);
      st(`CODE_EMPTY);
   endtask
   task s_empty;
      wr(2'h0, 8'h03);
      st(`CODE_EMPTY);
      pr;
      rd(2'h1);
      chk("reqstatus", rdv & 8'h04, 8'h00);
   endtask
   task printVerdict;
      $display("errors %0d checks %0d", numErrors, testsRun);
      if (numErrors == 0 && testsRun > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      #40000;
      numErrors++;
      printVerdict;
   end
   initial
   begin
      {rst_n, regWrite, regRead, insB, press} = 5'h0;
      insA = 1'b1;
      regAddr = 2'h0;
      regWrData = 8'h00;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      s_reset;
      s_swRequest;
      s_allowed;
      s_pressAllowed;
      s_leave;
      s_removeQuiet;
      s_removeWake;
      s_forced;
      s_empty;
      printVerdict;
   end
endmodule
